// ===== core/wtc_pkg.sv
// Package with register map, field positions and reset values of the wake timer clock control.
package wtc_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_CLOCK_GATE = 12'ha18;
   localparam logic [11:0] OFF_WAKE_CTRL = 12'ha20;
   localparam logic [11:0] OFF_T0_RELOAD_LOW = 12'ha24;
   localparam logic [11:0] OFF_T0_RELOAD_HIGH = 12'ha28;
   localparam logic [11:0] OFF_T1_RELOAD = 12'ha2c;
   localparam logic [11:0] OFF_T0_VALUE_LOW = 12'ha30;
   localparam logic [11:0] OFF_T0_VALUE_HIGH = 12'ha34;
   localparam logic [11:0] OFF_T1_VALUE = 12'ha38;
   localparam logic [11:0] OFF_STATUS = 12'ha3c;
   localparam int BIT_FLASH_CLK = 0;
   localparam int BIT_CRYSTAL_CLK = 1;
   localparam int BIT_OSC_1M_CLK = 2;
   localparam int BIT_T0_RUN = 0;
   localparam int BIT_T1_RUN = 1;
   localparam int BIT_T0_CLK = 2;
   localparam int BIT_T1_CLK = 3;
   localparam int BIT_T0_TIMEOUT = 0;
   localparam int BIT_T1_TIMEOUT = 1;
   localparam int BIT_T0_RUNNING = 2;
   localparam int BIT_T1_RUNNING = 3;
   localparam int T0_WIDTH = 41;
   localparam int T0_HIGH_WIDTH = 9;
   localparam int T1_WIDTH = 28;
   localparam logic [2:0] RST_CLOCK_GATE = 3'h1;
   localparam logic [3:0] RST_WAKE_CTRL = 4'h0;
   localparam logic [31:0] RST_T0_RELOAD_LOW = 32'h0000_0000;
   localparam logic [8:0] RST_T0_RELOAD_HIGH = 9'h000;
   localparam logic [27:0] RST_T1_RELOAD = 28'h000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ===== core/wtc_count_if.sv
// Interface carrying one wake timer's control and state between the register file and a counter.
`timescale 1ns/1ps
interface wtc_count_if #(parameter int WIDTH = 28);
   logic clkEn;
   logic runEn;
   logic [WIDTH-1:0] reload;
   logic [WIDTH-1:0] value;
   logic running;
   logic timeout;
   modport ctrl (output clkEn, output runEn, output reload,
      input value, input running, input timeout);
   modport cnt (input clkEn, input runEn, input reload,
      output value, output running, output timeout);
endinterface

// ===== core/wtc_down_counter.sv
// Down counter of one wake timer, started from its reload value.
`timescale 1ns/1ps
module wtc_down_counter #(
   parameter int WIDTH = 28
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   wtc_count_if.cnt port
);
   logic armed;
   logic [WIDTH-1:0] count;
   logic done;

   assign port.value = count;
   assign port.running = armed && !done && port.clkEn;
   assign port.timeout = done;

   // Dropping the run enable rearms the timer so the next start reloads.
   always_ff @(posedge clk) begin
      if (rst || !port.runEn) begin
         armed <= 1'b0;
         done <= 1'b0;
         count <= '1;
      end else if (!armed) begin
         armed <= 1'b1;
         count <= port.reload;
         done <= (port.reload == '0);
      end else if (port.clkEn && tick && !done) begin
         count <= count - WIDTH'(1);
         done <= (count == WIDTH'(1));
      end
   end
endmodule

// ===== core/wtc_top.sv
// AHB-Lite register block for wake timer control, reload values and system clock gates.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module wtc_top #(
   parameter int TICK_DIV = 200
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic oscMeasureClkEn,
   output logic crystalMeasureClkEn,
   output logic flashClkEn,
   output logic timer0Timeout,
   output logic timer1Timeout
);
   logic [2:0] clockGate;
   logic [3:0] wakeCtrl;
   logic [31:0] t0ReloadLow;
   logic [8:0] t0ReloadHigh;
   logic [27:0] t1Reload;
   logic wrPending;
   logic [11:0] wrAddr;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ = 2'b10
   } wtc_phase_e;

   wtc_phase_e phase;
   wtc_phase_e next_phase;
   logic wrClockGate;
   logic wrWakeCtrl;
   logic wrT0ReloadLow;
   logic wrT0ReloadHigh;
   logic wrT1Reload;
   logic [3:0] statusWord;
   logic [31:0] next_rdata;
   logic [31:0] tickCount;
   logic tick;

   wtc_count_if #(.WIDTH(wtc_pkg::T0_WIDTH)) t0If();
   wtc_count_if #(.WIDTH(wtc_pkg::T1_WIDTH)) t1If();

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, always OKAY.

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   logic accept;
   assign accept = hsel && hready && htrans == wtc_pkg::HTRANS_NONSEQ;

   always_ff @(posedge clk) begin
      if (rst) begin
         wrAddr <= 12'h000;
      end else if (accept) begin
         wrAddr <= haddr[11:0];
      end
   end

   // Only a write needs the data phase: its data arrive one cycle after the address.
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= PH_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   // Back-to-back transfers are allowed, so every phase may start a new one.
   always_comb begin
      next_phase = PH_IDLE;
      case (phase)
         PH_IDLE, PH_WRITE, PH_READ: begin
            if (accept && hwrite) begin
               next_phase = PH_WRITE;
            end else if (accept) begin
               next_phase = PH_READ;
            end else begin
               next_phase = PH_IDLE;
            end
         end
         default: begin
            next_phase = PH_IDLE;
         end
      endcase
   end

   assign wrPending = (phase == PH_WRITE);

   ////////////////////////////////////////////////////////////////////////////
   // Register file.

   // One strobe per register keeps each stored word in a process of its own.
   always_comb begin
      wrClockGate = 1'b0;
      wrWakeCtrl = 1'b0;
      wrT0ReloadLow = 1'b0;
      wrT0ReloadHigh = 1'b0;
      wrT1Reload = 1'b0;
      if (wrPending) begin
         case (wrAddr)
            wtc_pkg::OFF_CLOCK_GATE: wrClockGate = 1'b1;
            wtc_pkg::OFF_WAKE_CTRL: wrWakeCtrl = 1'b1;
            wtc_pkg::OFF_T0_RELOAD_LOW: wrT0ReloadLow = 1'b1;
            wtc_pkg::OFF_T0_RELOAD_HIGH: wrT0ReloadHigh = 1'b1;
            wtc_pkg::OFF_T1_RELOAD: wrT1Reload = 1'b1;
            default: begin
               wrClockGate = 1'b0;
            end
         endcase
      end
   end

   // Reserved bits are dropped on write and read back as zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         clockGate <= wtc_pkg::RST_CLOCK_GATE;
      end else if (wrClockGate) begin
         clockGate <= hwdata[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wakeCtrl <= wtc_pkg::RST_WAKE_CTRL;
      end else if (wrWakeCtrl) begin
         wakeCtrl <= hwdata[3:0];
      end
   end

   // Reload words are not guarded: a write while running only takes effect at the next start.
   always_ff @(posedge clk) begin
      if (rst) begin
         t0ReloadLow <= wtc_pkg::RST_T0_RELOAD_LOW;
      end else if (wrT0ReloadLow) begin
         t0ReloadLow <= hwdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         t0ReloadHigh <= wtc_pkg::RST_T0_RELOAD_HIGH;
      end else if (wrT0ReloadHigh) begin
         t0ReloadHigh <= hwdata[8:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         t1Reload <= wtc_pkg::RST_T1_RELOAD;
      end else if (wrT1Reload) begin
         t1Reload <= hwdata[27:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path.

   always_comb begin
      statusWord = 4'h0;
      statusWord[wtc_pkg::BIT_T0_TIMEOUT] = t0If.timeout;
      statusWord[wtc_pkg::BIT_T1_TIMEOUT] = t1If.timeout;
      statusWord[wtc_pkg::BIT_T0_RUNNING] = t0If.running;
      statusWord[wtc_pkg::BIT_T1_RUNNING] = t1If.running;
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr[11:0])
         wtc_pkg::OFF_CLOCK_GATE: next_rdata[2:0] = clockGate;
         wtc_pkg::OFF_WAKE_CTRL: next_rdata[3:0] = wakeCtrl;
         wtc_pkg::OFF_T0_RELOAD_LOW: next_rdata = t0ReloadLow;
         wtc_pkg::OFF_T0_RELOAD_HIGH: next_rdata[8:0] = t0ReloadHigh;
         wtc_pkg::OFF_T1_RELOAD: next_rdata[27:0] = t1Reload;
         wtc_pkg::OFF_T0_VALUE_LOW: next_rdata = t0If.value[31:0];
         wtc_pkg::OFF_T0_VALUE_HIGH: next_rdata[8:0] = t0If.value[40:32];
         wtc_pkg::OFF_T1_VALUE: next_rdata[27:0] = t1If.value;
         wtc_pkg::OFF_STATUS: next_rdata[3:0] = statusWord;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (accept && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock gates and timer wiring.

   assign oscMeasureClkEn = clockGate[wtc_pkg::BIT_OSC_1M_CLK];
   assign crystalMeasureClkEn = clockGate[wtc_pkg::BIT_CRYSTAL_CLK];
   assign flashClkEn = clockGate[wtc_pkg::BIT_FLASH_CLK];

   assign t0If.clkEn = wakeCtrl[wtc_pkg::BIT_T0_CLK];
   assign t1If.clkEn = wakeCtrl[wtc_pkg::BIT_T1_CLK];
   assign t0If.runEn = wakeCtrl[wtc_pkg::BIT_T0_RUN];
   assign t1If.runEn = wakeCtrl[wtc_pkg::BIT_T1_RUN];
   assign t0If.reload = {t0ReloadHigh, t0ReloadLow};
   assign t1If.reload = t1Reload;
   assign timer0Timeout = t0If.timeout;
   assign timer1Timeout = t1If.timeout;

   // The timer clock is modelled as a tick derived from the bus clock.
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         tickCount <= 32'h0000_0000;
      end else begin
         tickCount <= tickCount + 32'h0000_0001;
      end
   end
   assign tick = (tickCount == 32'(TICK_DIV - 1));

   wtc_down_counter #(.WIDTH(wtc_pkg::T0_WIDTH)) timer0 (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .port(t0If.cnt)
   );

   wtc_down_counter #(.WIDTH(wtc_pkg::T1_WIDTH)) timer1 (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .port(t1If.cnt)
   );
endmodule

// ===== dv/wtc_checker.sv
// Concurrent checks on the bus and clock gate ports of the wake timer block.
`timescale 1ns/1ps
module wtc_checker #(
   parameter int TICK_DIV = 200
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic oscMeasureClkEn,
   input wire logic crystalMeasureClkEn,
   input wire logic flashClkEn,
   input wire logic timer0Timeout,
   input wire logic timer1Timeout
);
   logic dWr, dRd;
   logic [11:0] dAddr;
   always_ff @(posedge clk) begin
      dWr <= !rst && hsel && hready && htrans == 2'h2 && hwrite;
      dRd <= !rst && hsel && hready && htrans == 2'h2 && !hwrite;
      dAddr <= haddr[11:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence gateWr;
      dWr && dAddr == 12'ha18;
   endsequence
   // The gate outputs follow the stored word directly, yet the check still waits for two cycles without a write.
   sequence noGateWr;
      !dWr ##1 !dWr;
   endsequence
   chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   chk_gate_reset: assert property (disable iff (1'b0) $fell(rst) |-> flashClkEn && !oscMeasureClkEn && !crystalMeasureClkEn) else $error("gate reset value wrong");
   chk_osc_write: assert property (gateWr |-> ##2 oscMeasureClkEn == $past(hwdata[2], 2)) else $error("osc gate not written");
   chk_xtal_write: assert property (gateWr |-> ##2 crystalMeasureClkEn == $past(hwdata[1], 2)) else $error("crystal gate not written");
   chk_flash_write: assert property (gateWr |-> ##2 flashClkEn == $past(hwdata[0], 2)) else $error("flash gate not written");
   chk_gate_hold: assert property (noGateWr |=> $stable({oscMeasureClkEn, crystalMeasureClkEn, flashClkEn})) else $error("gate moved without write");
   chk_status_read: assert property (dRd && dAddr == 12'ha3c |-> hrdata[1:0] == $past({timer1Timeout, timer0Timeout})) else $error("status timeout bits wrong");
   chk_t1_reserved: assert property (dRd && dAddr == 12'ha2c |-> hrdata[31:28] == 4'h0) else $error("reload reserved bits set");
endmodule
////////////////////////////////////////////////////////////////////////////////////////////////
bind wtc_top wtc_checker #(.TICK_DIV(TICK_DIV)) chk_u (.clk(clk), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .oscMeasureClkEn(oscMeasureClkEn),
   .crystalMeasureClkEn(crystalMeasureClkEn), .flashClkEn(flashClkEn),
   .timer0Timeout(timer0Timeout), .timer1Timeout(timer1Timeout));

// ===== dv/wtc_top_tb.sv
// Self-checking bench for the wake timer clock control block.
`timescale 1ns/1ps
module wtc_top_tb;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, rdPh = 0, hreadyout, hresp, osc, xtal, fl, t0, t1;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic [31:0] expQ[$];
   int failures = 0, checked = 0, n;
   wtc_top #(.TICK_DIV(2)) dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .oscMeasureClkEn(osc),
      .crystalMeasureClkEn(xtal), .flashClkEn(fl), .timer0Timeout(t0), .timer1Timeout(t1));
   initial forever #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitRdy();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic bus(input bit wr, input logic [11:0] a, input logic [31:0] d);
      haddr <= {20'h0, a};
      hwrite <= wr;
      hsel <= 1'b1;
      htrans <= wtc_pkg::HTRANS_NONSEQ;
      waitRdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      rdPh <= !wr;
      waitRdy();
      rdPh <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Read data is only meaningful at the edge that closes its data phase.
   always @(posedge clk) if (rdPh && hreadyout === 1'b1) check(hrdata, expQ.pop_front());
   initial begin
      void'($urandom(32'hd5903e1d));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({29'h0, osc, xtal, fl}, 32'h1);
      rd(12'ha18, 32'h1);
      for (int a = 12'ha20; a <= 12'ha2c; a += 4) rd(a[11:0], 32'h0);
      repeat (4) begin
         r = $urandom;
         bus(1'b1, 12'ha18, r);
         @(posedge clk);
         #1 check({29'h0, osc, xtal, fl}, {29'h0, r[2:0]});
         rd(12'ha18, {29'h0, r[2:0]});
      end
      bus(1'b1, 12'ha28, 32'hffff_ffff);
      rd(12'ha28, 32'h1ff);
      bus(1'b1, 12'ha2c, 32'hffff_ffff);
      rd(12'ha2c, 32'h0fff_ffff);
      bus(1'b1, 12'ha1c, 32'hffff_ffff);
      rd(12'ha1c, 32'h0);
      bus(1'b1, 12'ha28, 32'h0);
      $display("register test done");
      for (int i = 0; i < 2; i++) begin
         r = 32'd8 + ($urandom % 8);
         bus(1'b1, i ? 12'ha2c : 12'ha24, r);
         bus(1'b1, 12'ha20, 32'h1 << i);
         repeat (40) @(posedge clk);
         check({31'h0, i ? t1 : t0}, 32'h0);
         bus(1'b1, 12'ha20, 32'h5 << i);
         rd(12'ha3c, 32'h4 << i);
         for (n = 0; (i ? t1 : t0) !== 1'b1 && n < 200; n++) @(posedge clk);
         check({31'h0, n < 200 && n >= 2 * r - 10}, 32'h1);
         if (n >= 200) stop_test();
         rd(12'ha3c, 32'h1 << i);
         bus(1'b1, 12'ha20, 32'h0);
         repeat (2) @(posedge clk);
         #1 check({31'h0, i ? t1 : t0}, 32'h0);
         $display("timer %0d test done", i);
      end
      rd(12'ha30, 32'hffff_ffff);
      rd(12'ha34, 32'h0000_01ff);
      rd(12'ha38, 32'h0fff_ffff);
      rd(12'ha38, 32'h0fff_ffff);
      $display("value test done");
      stop_test();
   end
endmodule
